// [design/hdp_pkg.sv]
package hdp_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_ENABLE = 8'h48;
	localparam logic [7:0] IDX_SPEED = 8'h49;
	localparam logic [7:0] IDX_LINE_DATA = 8'h4A;
	localparam logic [7:0] IDX_FORCE_CTL = 8'h4B;
	localparam logic [7:0] IDX_SE0_STATE = 8'h4F;
	localparam logic [7:0] IDX_PULL_LOW = 8'h51;

	localparam logic [3:0] RST_ENABLE = 4'h0;
	localparam logic [3:0] RST_SPEED = 4'h0;
	localparam logic [3:0] RST_LINE_DATA = 4'h0;
	localparam logic [7:0] RST_FORCE_CTL = 8'h00;
	localparam logic [7:0] RST_PULL_LOW = 8'h00;

	// upper nibble of the four-bit registers reads as zero
	localparam logic [3:0] RSV_NIBBLE = 4'h0;
	localparam logic [23:0] RSV_UPPER = 24'h000000;

	// force-control codes, two bits per port, port 1 in the lowest pair
	localparam logic [1:0] FC_NORMAL = 2'h0;
	localparam logic [1:0] FC_DIFF1 = 2'h1;
	localparam logic [1:0] FC_DIFF0 = 2'h2;
	localparam logic [1:0] FC_SE0 = 2'h3;
	localparam int FC_WIDTH = 2;

	// pull-low layout: positive line in the upper bit of each pair
	localparam int PL_DP_BIT = 1;
	localparam int PL_DM_BIT = 0;

	localparam int NUM_PORTS = 4;
	localparam int CLK_HZ = 10000000;
endpackage

// [design/hdp_port_ctl.sv]
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
// Behaviour
// (RULE_01) a set enable bit opens the port for traffic both ways
// (RULE_02) open unsuspended port gets upstream traffic and forwards its own upstream
// (RULE_03) low speed ports never get full speed upstream traffic
// (RULE_04) enabling waits for the current packet to end, immediate when idle
// (RULE_05) in suspend a connect or disconnect raises the hub interrupt if enabled
// (RULE_06) enable register clears on chip reset and on bus reset
// (RULE_07) babble clears the port enable; non-idle line at EOF2 is babble
// (RULE_08) upstream connectivity still held at EOF2 is also babble
// (RULE_09) force code: 00 normal, 01 J, 10 K, 11 SE0; code drives 01 as D+ high, 10 as D- high at both speeds
// (RULE_10) two force bits per port, port 1 lowest, upper bit is bit 1
// (RULE_11) force register clears on chip reset only
// (RULE_12) firmware disables a port before forcing it
// (RULE_13) forced levels use edge-rate control matched to port speed
// (RULE_14) firmware clears all force codes before suspend
// (RULE_15) pull-low bits drive single pins low, no edge-rate control
// (RULE_16) pulled-low pins stay low during suspend
// (RULE_17) firmware holds SE0 through pull-low while unconfigured
// (RULE_18) line-data readback is differential state only, speed ignored
// (RULE_19) SE0 state bit reads 1 while port lines are SE0
// (RULE_20) speed register clears on chip and bus reset, firmware sets it
// (RULE_21) reserved upper bits of the speed register read zero
// (RULE_22) firmware enables a port only after host port reset request
// (RULE_23) speed bit 1 means low speed, 0 full speed
// (RULE_24) babble checked once per frame at EOF2, clears only offending ports
module hdp_port_ctl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic usb_bus_reset,
	input wire logic hub_suspended,
	input wire logic hub_int_enable,
	input wire logic [3:0] conn_change,
	output logic hub_int_req,
	input wire logic eof2_tick,
	input wire logic us_pkt_busy,
	input wire logic us_pkt_fs,
	input wire logic us_tx_oe,
	input wire logic us_tx_dp,
	input wire logic us_tx_dm,
	input wire logic [3:0] port_us_owner,
	output logic [3:0] ds_rx_fwd,
	input wire logic [3:0] ds_dp_i,
	input wire logic [3:0] ds_dm_i,
	output logic [3:0] ds_dp_o,
	output logic [3:0] ds_dm_o,
	output logic [3:0] ds_dp_oe,
	output logic [3:0] ds_dm_oe,
	output logic [3:0] ds_edge_ctl,
	output logic [3:0] ds_edge_ls
);
	logic ack_ff;
	logic [7:0] rd_ff;
	logic [3:0] en_ff;
	logic [3:0] act_ff;
	logic [3:0] spd_ff;
	logic [3:0] dd_ff;
	logic [7:0] fc_ff;
	logic [7:0] pl_ff;
	logic int_ff;
	logic [3:0] dp_m_ff;
	logic [3:0] dm_m_ff;
	logic [3:0] dp_s_ff;
	logic [3:0] dm_s_ff;
	logic [3:0] fwd_ff;
	logic [3:0] dpo_ff;
	logic [3:0] dmo_ff;
	logic [3:0] dpoe_ff;
	logic [3:0] dmoe_ff;
	logic [3:0] edge_ff;

	wire [7:0] adr_idx = wb_adr_i[9:2];
	wire adr_top_ok = (wb_adr_i[11:10] == 2'h0);
	wire req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master samples ack
	wire wr_fire = req & wb_we_i & ack_ff & wb_sel_i[0];
	wire hit_en = adr_top_ok & (adr_idx == hdp_pkg::IDX_ENABLE);
	wire hit_spd = adr_top_ok & (adr_idx == hdp_pkg::IDX_SPEED);
	wire hit_dd = adr_top_ok & (adr_idx == hdp_pkg::IDX_LINE_DATA);
	wire hit_fc = adr_top_ok & (adr_idx == hdp_pkg::IDX_FORCE_CTL);
	wire hit_se0 = adr_top_ok & (adr_idx == hdp_pkg::IDX_SE0_STATE);
	wire hit_pl = adr_top_ok & (adr_idx == hdp_pkg::IDX_PULL_LOW);
	wire [7:0] wdat = wb_dat_i[7:0];

	wire [3:0] se0_v = ~dp_s_ff & ~dm_s_ff;
	wire [3:0] diff_v = dp_s_ff ^ dm_s_ff;
	wire [3:0] forced_v;
	wire [3:0] pl_any_v;
	wire [3:0] pl_dp_v;
	wire [3:0] tx_pass_v;
	wire [3:0] babble_v;
	wire [3:0] nxt_dp;
	wire [3:0] nxt_dm;
	wire [3:0] nxt_dpoe;
	wire [3:0] nxt_dmoe;
	wire [3:0] nxt_edge;

	// unmapped indices read zero and swallow writes, still acked
	wire [7:0] rd_mux = hit_en ? {hdp_pkg::RSV_NIBBLE, en_ff} :
		hit_spd ? {hdp_pkg::RSV_NIBBLE, spd_ff} : // RULE_21
		hit_dd ? {hdp_pkg::RSV_NIBBLE, dd_ff} :
		hit_fc ? fc_ff :
		hit_se0 ? {hdp_pkg::RSV_NIBBLE, se0_v} : // RULE_19
		hit_pl ? pl_ff : 8'h00;

	// a babble clear beats a firmware write in the same cycle
	wire [3:0] nxt_en = usb_bus_reset ? hdp_pkg::RST_ENABLE : // RULE_06
		((wr_fire & hit_en) ? wdat[3:0] : en_ff) & ~babble_v; // RULE_07
	// opening waits for the packet end, closing never waits
	wire [3:0] nxt_act = (us_pkt_busy ? (act_ff & en_ff) : en_ff) & ~babble_v & // RULE_04
		{4{~usb_bus_reset}};
	wire [3:0] nxt_spd = usb_bus_reset ? hdp_pkg::RST_SPEED : // RULE_20
		((wr_fire & hit_spd) ? wdat[3:0] : spd_ff);
	// hold the last differential value through SE0 and SE1
	wire [3:0] nxt_dd = usb_bus_reset ? hdp_pkg::RST_LINE_DATA :
		(diff_v & dp_s_ff) | (~diff_v & dd_ff); // RULE_18
	wire [7:0] nxt_fc = (wr_fire & hit_fc) ? wdat : fc_ff; // RULE_11
	wire [7:0] nxt_pl = (wr_fire & hit_pl) ? wdat : pl_ff;
	wire nxt_int = hub_suspended & hub_int_enable & (|conn_change); // RULE_05
	wire [3:0] nxt_fwd = act_ff & ~{4{hub_suspended}}; // RULE_02

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_port
			wire [1:0] fc = fc_ff[gi*hdp_pkg::FC_WIDTH +: hdp_pkg::FC_WIDTH]; // RULE_10
			wire pl_dp = pl_ff[gi*2 + hdp_pkg::PL_DP_BIT]; // RULE_15
			wire pl_dm = pl_ff[gi*2 + hdp_pkg::PL_DM_BIT];
			// J differs between speeds: low speed idles with D- high
			wire idle_j = spd_ff[gi] ? (~dp_s_ff[gi] & dm_s_ff[gi]) : // RULE_23
				(dp_s_ff[gi] & ~dm_s_ff[gi]);
			assign forced_v[gi] = (fc != hdp_pkg::FC_NORMAL);
			assign pl_any_v[gi] = pl_dp | pl_dm;
			assign pl_dp_v[gi] = pl_dp;
			assign tx_pass_v[gi] = act_ff[gi] & ~hub_suspended & us_tx_oe & // RULE_01
				~(spd_ff[gi] & us_pkt_fs); // RULE_03
			assign babble_v[gi] = eof2_tick & act_ff[gi] & // RULE_24
				(~idle_j | port_us_owner[gi]); // RULE_08
			assign nxt_dp[gi] = pl_dp ? 1'h0 :
				forced_v[gi] ? (fc == hdp_pkg::FC_DIFF1) : us_tx_dp; // RULE_09
			assign nxt_dm[gi] = pl_dm ? 1'h0 :
				forced_v[gi] ? (fc == hdp_pkg::FC_DIFF0) : us_tx_dm; // RULE_09
			assign nxt_dpoe[gi] = pl_dp | forced_v[gi] | tx_pass_v[gi]; // RULE_16
			assign nxt_dmoe[gi] = pl_dm | forced_v[gi] | tx_pass_v[gi];
			// pull-low is a raw pin drive, rate control would slow it
			assign nxt_edge[gi] = ~pl_any_v[gi] & (forced_v[gi] | tx_pass_v[gi]); // RULE_13
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_ff <= 1'h0;
			rd_ff <= 8'h00;
		end else begin
			ack_ff <= req & ~ack_ff;
			rd_ff <= (req & ~ack_ff) ? rd_mux : rd_ff;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_ff <= hdp_pkg::RST_ENABLE; // RULE_06
			act_ff <= 4'h0;
			spd_ff <= hdp_pkg::RST_SPEED; // RULE_20
			dd_ff <= hdp_pkg::RST_LINE_DATA;
			fc_ff <= hdp_pkg::RST_FORCE_CTL; // RULE_11
			pl_ff <= hdp_pkg::RST_PULL_LOW;
			int_ff <= 1'h0;
		end else begin
			en_ff <= nxt_en;
			act_ff <= nxt_act;
			spd_ff <= nxt_spd;
			dd_ff <= nxt_dd;
			fc_ff <= nxt_fc;
			pl_ff <= nxt_pl;
			int_ff <= nxt_int;
		end
	end

	// pins come from another domain, two stages before any use
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dp_m_ff <= 4'h0;
			dm_m_ff <= 4'h0;
			dp_s_ff <= 4'h0;
			dm_s_ff <= 4'h0;
		end else begin
			dp_m_ff <= ds_dp_i;
			dm_m_ff <= ds_dm_i;
			dp_s_ff <= dp_m_ff;
			dm_s_ff <= dm_m_ff;
		end
	end

	// registered pin drive costs one cycle of repeat latency
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fwd_ff <= 4'h0;
			dpo_ff <= 4'h0;
			dmo_ff <= 4'h0;
			dpoe_ff <= 4'h0;
			dmoe_ff <= 4'h0;
			edge_ff <= 4'h0;
		end else begin
			fwd_ff <= nxt_fwd;
			dpo_ff <= nxt_dp;
			dmo_ff <= nxt_dm;
			dpoe_ff <= nxt_dpoe;
			dmoe_ff <= nxt_dmoe;
			edge_ff <= nxt_edge;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = {hdp_pkg::RSV_UPPER, rd_ff};
	assign hub_int_req = int_ff;
	assign ds_rx_fwd = fwd_ff;
	assign ds_dp_o = dpo_ff;
	assign ds_dm_o = dmo_ff;
	assign ds_dp_oe = dpoe_ff;
	assign ds_dm_oe = dmoe_ff;
	assign ds_edge_ctl = edge_ff;
	assign ds_edge_ls = spd_ff; // RULE_13

	sequence s_babble;
		eof2_tick && (babble_v != 4'h0);
	endsequence

	sequence s_rd_req(logic hit);
		req && !wb_we_i && !ack_ff && hit;
	endsequence

	a_open_forward: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
		1'h1 |=> ds_rx_fwd == ($past(act_ff) & ~{4{$past(hub_suspended)}}))
		else $error("forward select does not follow open ports");

	a_ls_blocked: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
		us_pkt_fs |=> (ds_dp_oe & $past(spd_ff & ~forced_v & ~pl_any_v)) == 4'h0)
		else $error("full speed traffic reached a low speed port");

	a_open_waits: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
		us_pkt_busy |=> (act_ff & ~$past(act_ff)) == 4'h0)
		else $error("port opened during a packet");

	a_open_idle: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
		!us_pkt_busy && !usb_bus_reset && !eof2_tick ##1 !us_pkt_busy |-> act_ff == $past(en_ff))
		else $error("idle bus did not open enabled port at once");

	a_bus_reset: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
		usb_bus_reset |=> en_ff == 4'h0 && spd_ff == 4'h0 && act_ff == 4'h0)
		else $error("bus reset left enable or speed set");

	a_babble_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
		s_babble and !wr_fire and !usb_bus_reset |=>
		(en_ff & $past(babble_v)) == 4'h0 && (en_ff & ~$past(babble_v)) == ($past(en_ff) & ~$past(babble_v)))
		else $error("babble clear wrong set of ports");

	a_no_frame: assert property (@(posedge clk) disable iff (!resetn) // RULE_24
		!eof2_tick |-> babble_v == 4'h0)
		else $error("babble flagged outside EOF2");

	a_force_j: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
		fc_ff[1:0] == hdp_pkg::FC_DIFF1 && pl_ff[1:0] == 2'h0 |=>
		ds_dp_o[0] && !ds_dm_o[0] && ds_dp_oe[0] && ds_dm_oe[0] && ds_edge_ctl[0])
		else $error("port 1 force J not driven");

	a_force_se0: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
		fc_ff[7:6] == hdp_pkg::FC_SE0 && pl_ff[7:6] == 2'h0 |=>
		!ds_dp_o[3] && !ds_dm_o[3] && ds_dp_oe[3] && ds_dm_oe[3])
		else $error("port 4 force SE0 not driven");

	a_pull_low: assert property (@(posedge clk) disable iff (!resetn) // RULE_16
		pl_ff[7] |=> ds_dp_oe[3] && !ds_dp_o[3] && !ds_edge_ctl[3])
		else $error("pulled-low pin not held low");

	a_susp_int: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
		hub_suspended && hub_int_enable && conn_change != 4'h0 |=> hub_int_req)
		else $error("suspend connect change missed interrupt");

	a_se0_read: assert property (@(posedge clk) disable iff (!resetn) // RULE_19
		s_rd_req(hit_se0) |=> wb_ack_o && wb_dat_o == {28'h0000000, $past(se0_v)})
		else $error("SE0 state readback wrong");

	a_spd_rsv: assert property (@(posedge clk) disable iff (!resetn) // RULE_21
		s_rd_req(hit_spd) |=> wb_ack_o && wb_dat_o[31:4] == 28'h0000000 && wb_dat_o[3:0] == $past(spd_ff))
		else $error("speed readback wrong or reserved bits set");

	sequence s_wr_hit(logic hit);
		req && wb_we_i && ack_ff && wb_sel_i[0] && hit;
	endsequence

	// closing never waits for a packet end, so an open port always had its enable bit the cycle before
	a_closed_quiet: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
		1'h1 |=> (act_ff & ~$past(en_ff)) == 4'h0)
		else $error("port open without its enable bit");

	a_susp_no_fwd: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
		hub_suspended |=> ds_rx_fwd == 4'h0)
		else $error("port forwarded upstream during suspend");

	a_susp_no_pass: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
		hub_suspended |=> (ds_dp_oe & $past(~forced_v & ~pl_dp_v)) == 4'h0)
		else $error("upstream traffic repeated during suspend");

	a_repeat_data: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
		1'h1 |=> ((ds_dp_o ^ {4{$past(us_tx_dp)}}) & $past(tx_pass_v & ~forced_v & ~pl_any_v)) == 4'h0)
		else $error("open port did not repeat upstream data");

	a_open_after: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
		$fell(us_pkt_busy) && !usb_bus_reset && !eof2_tick |=> act_ff == $past(en_ff))
		else $error("port not opened at packet end");

	a_babble_owner: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
		eof2_tick && (port_us_owner & act_ff) != 4'h0 |=> ((act_ff | en_ff) & $past(port_us_owner & act_ff)) == 4'h0)
		else $error("port holding upstream at frame end stayed open");

	a_babble_fs: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
		eof2_tick |-> (act_ff & ~spd_ff & ~(dp_s_ff & ~dm_s_ff) & ~babble_v) == 4'h0)
		else $error("full speed non-idle line not flagged");

	a_babble_ls: assert property (@(posedge clk) disable iff (!resetn) // RULE_23
		eof2_tick |-> (act_ff & spd_ff & ~(~dp_s_ff & dm_s_ff) & ~babble_v) == 4'h0)
		else $error("low speed non-idle line not flagged");

	a_babble_scope: assert property (@(posedge clk) disable iff (!resetn) // RULE_24
		1'h1 |-> (babble_v & ~act_ff) == 4'h0)
		else $error("babble flagged on a closed port");

	a_int_quiet: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
		!(hub_suspended && hub_int_enable) |=> !hub_int_req)
		else $error("interrupt raised outside enabled suspend");

	a_fc_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
		usb_bus_reset && !wr_fire |=> fc_ff == $past(fc_ff) && pl_ff == $past(pl_ff))
		else $error("bus reset disturbed force or pull-low bits");

	a_force_k: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
		fc_ff[3:2] == hdp_pkg::FC_DIFF0 && pl_ff[3:2] == 2'h0 |=>
		!ds_dp_o[1] && ds_dm_o[1] && ds_dp_oe[1] && ds_dm_oe[1] && ds_edge_ctl[1])
		else $error("port 2 force K not driven");

	a_force_edge: assert property (@(posedge clk) disable iff (!resetn) // RULE_13
		(forced_v & ~pl_any_v) != 4'h0 |=> (ds_edge_ctl & $past(forced_v & ~pl_any_v)) == $past(forced_v & ~pl_any_v))
		else $error("forced port without edge-rate control");

	a_pull_dm: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
		pl_ff[0] |=> ds_dm_oe[0] && !ds_dm_o[0] && !ds_edge_ctl[0])
		else $error("port 1 negative line not pulled low");

	a_pull_any: assert property (@(posedge clk) disable iff (!resetn) // RULE_16
		1'h1 |=> ((~ds_dp_oe | ds_dp_o) & $past(pl_dp_v)) == 4'h0)
		else $error("pulled-low positive line released");

	a_line_diff: assert property (@(posedge clk) disable iff (!resetn) // RULE_18
		!usb_bus_reset |=> ((dd_ff ^ $past(dp_s_ff)) & $past(diff_v)) == 4'h0)
		else $error("line data does not follow differential state");

	a_line_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE_18
		!usb_bus_reset |=> ((dd_ff ^ $past(dd_ff)) & ~$past(diff_v)) == 4'h0)
		else $error("line data changed on a single-ended state");

	a_line_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE_18
		usb_bus_reset |=> dd_ff == 4'h0)
		else $error("bus reset left line data set");

	a_en_write: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
		s_wr_hit(hit_en) ##0 (!usb_bus_reset && !eof2_tick) |=> en_ff == $past(wb_dat_i[3:0]))
		else $error("enable write not taken");

	a_fc_write: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
		s_wr_hit(hit_fc) |=> fc_ff == $past(wb_dat_i[7:0]))
		else $error("force-control write not taken");

	a_pl_write: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
		s_wr_hit(hit_pl) |=> pl_ff == $past(wb_dat_i[7:0]))
		else $error("pull-low write not taken");

	a_spd_write: assert property (@(posedge clk) disable iff (!resetn) // RULE_20
		s_wr_hit(hit_spd) ##0 !usb_bus_reset |=> spd_ff == $past(wb_dat_i[3:0]))
		else $error("speed write not taken");
endmodule

// [test/hdp_dev_model.sv]
`timescale 1ns/100ps
// four attached devices; an undriven pin shows the device pull or the hub pull-down unless noisy forces K
module hdp_dev_model (
	input wire logic [3:0] ls,
	input wire logic [3:0] noisy,
	input wire logic [3:0] dp_o,
	input wire logic [3:0] dm_o,
	input wire logic [3:0] dp_oe,
	input wire logic [3:0] dm_oe,
	output logic [3:0] dp_i,
	output logic [3:0] dm_i
);
	// idle is J: full speed pulls D+ high, low speed pulls D- high; noisy flips to K
	wire logic [3:0] dp_idle = ~(ls ^ noisy);
	assign dp_i = (dp_oe & dp_o) | (~dp_oe & dp_idle);
	assign dm_i = (dm_oe & dm_o) | (~dm_oe & ~dp_idle);
endmodule

// [test/testbench.sv]
`timescale 1ns/100ps
module testbench;
	logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, busrst = 0, susp = 0, inten = 0, eof2 = 0;
	logic busy = 0, fs = 0, txoe = 0, txdp = 0, txdm = 0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0, chg = 4'h0, own = 4'h0, noisy = 4'h0, spd = 4'h2;
	logic [31:0] wdat = 32'h00000000;
	logic [7:0] q;
	int fail_count = 0, compares = 0, cycles = 0, p, b;
	wire logic [31:0] rdat;
	wire logic ack, irq;
	wire logic [3:0] fwd, dpi, dmi, dpo, dmo, dpoe, dmoe, ectl, els;
	hdp_port_ctl hdp_port_ctl_i (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.usb_bus_reset(busrst), .hub_suspended(susp), .hub_int_enable(inten), .conn_change(chg),
		.hub_int_req(irq), .eof2_tick(eof2), .us_pkt_busy(busy), .us_pkt_fs(fs), .us_tx_oe(txoe),
		.us_tx_dp(txdp), .us_tx_dm(txdm), .port_us_owner(own), .ds_rx_fwd(fwd), .ds_dp_i(dpi),
		.ds_dm_i(dmi), .ds_dp_o(dpo), .ds_dm_o(dmo), .ds_dp_oe(dpoe), .ds_dm_oe(dmoe),
		.ds_edge_ctl(ectl), .ds_edge_ls(els));
	hdp_dev_model hdp_dev_model_i (.ls(spd), .noisy(noisy), .dp_o(dpo), .dm_o(dmo), .dp_oe(dpoe),
		.dm_oe(dmoe), .dp_i(dpi), .dm_i(dmi));
	always #50 clk = ~clk;
	task complete_run();
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles > 6000) begin
			fail_count++;
			complete_run();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; the request is held until ack is seen at a rising edge
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {2'h0, idx, 2'h0};
		sel <= 4'hF;
		wdat <= {24'h000000, d};
		@(posedge clk);
		while (ack !== 1'h1) @(posedge clk);
		q = rdat[7:0];
		cyc <= 0;
		stb <= 0;
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		wb(0, idx, 8'h00);
		chk(q, exp);
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		b = $urandom(99);
		idle(3);
		resetn <= 1;
		rd(hdp_pkg::IDX_ENABLE, 8'h00);
		rd(hdp_pkg::IDX_SPEED, 8'h00);
		rd(hdp_pkg::IDX_FORCE_CTL, 8'h00);
		rd(hdp_pkg::IDX_PULL_LOW, 8'h00);
		// unconfigured hub holds SE0 on every port through the pull-low bits
		wb(1, hdp_pkg::IDX_PULL_LOW, 8'hFF);
		idle(3);
		chk({dpoe, dmoe}, 8'hFF);
		chk({dpo, dmo}, 8'h00);
		chk({4'h0, ectl}, 8'h00);
		rd(hdp_pkg::IDX_SE0_STATE, 8'h0F);
		wb(1, hdp_pkg::IDX_PULL_LOW, 8'h00);
		rd(8'h60, 8'h00);
		b = $urandom;
		wb(1, hdp_pkg::IDX_SPEED, b[7:0]);
		rd(hdp_pkg::IDX_SPEED, {4'h0, b[3:0]});
		wb(1, hdp_pkg::IDX_SPEED, {4'h0, spd});
		// enable during a packet must wait for its end
		txoe <= 1;
		txdp <= 1;
		fs <= 1;
		busy <= 1;
		wb(1, hdp_pkg::IDX_ENABLE, 8'h07);
		idle(4);
		chk({4'h0, fwd}, 8'h00);
		busy <= 0;
		idle(4);
		chk({4'h0, fwd}, 8'h07);
		chk({4'h0, dpoe}, 8'h05);
		txoe <= 0;
		fs <= 0;
		noisy <= 4'h1;
		own <= 4'h2;
		idle(4);
		eof2 <= 1;
		idle(1);
		eof2 <= 0;
		own <= 4'h0;
		noisy <= 4'h0;
		idle(2);
		rd(hdp_pkg::IDX_ENABLE, 8'h04);
		wb(1, hdp_pkg::IDX_FORCE_CTL, 8'hC9);
		busrst <= 1;
		idle(1);
		busrst <= 0;
		spd <= 4'h0;
		rd(hdp_pkg::IDX_ENABLE, 8'h00);
		rd(hdp_pkg::IDX_SPEED, 8'h00);
		rd(hdp_pkg::IDX_FORCE_CTL, 8'hC9);
		b = $urandom;
		wb(1, hdp_pkg::IDX_SPEED, {4'h0, b[3:0]});
		spd <= b[3:0];
		for (int c = 1; c < 4; c++) begin
			p = $urandom % 4;
			wb(1, hdp_pkg::IDX_FORCE_CTL, 8'(c << (2 * p)));
			idle(4);
			chk({2'h0, dpoe[p], dmoe[p], dpo[p], dmo[p], ectl[p], els[p]}, {4'h3, c == 1, c == 2, 1'h1, spd[p]});
			rd(hdp_pkg::IDX_SE0_STATE, 8'(c == 3) << p);
			if (c != 3) rd(hdp_pkg::IDX_LINE_DATA, {4'h0, (~spd & ~(4'h1 << p)) | (4'(c == 1) << p)});
		end
		wb(1, hdp_pkg::IDX_FORCE_CTL, 8'h00);
		susp <= 1;
		b = $urandom % 8;
		p = b / 2;
		wb(1, hdp_pkg::IDX_PULL_LOW, 8'h01 << b);
		idle(3);
		chk({5'h00, (b % 2 ? {dpoe[p], dpo[p], ectl[p]} : {dmoe[p], dmo[p], ectl[p]})}, 8'h04);
		inten <= 1;
		chg <= 4'h4;
		idle(1);
		chg <= 4'h0;
		idle(1);
		chk({7'h00, irq}, 8'h01);
		inten <= 0;
		chg <= 4'h1;
		idle(1);
		chg <= 4'h0;
		idle(1);
		chk({7'h00, irq}, 8'h00);
		complete_run();
	end
endmodule
